/* inc/tsc_pkg.sv */
// shared constants, register map and state types of the touch scan scheduler
`default_nettype none

package tsc_pkg;

  // clock and timebase
  localparam int CLK_MHZ       = 10;                   // system clock rate
  localparam int TICK_US       = 10;                   // timebase tick period
  localparam int TICK_CYCLES   = TICK_US * CLK_MHZ;    // clocks per tick
  localparam int CAL_LIMIT_MS  = 600;                  // longest recalibration window
  localparam int CAL_TICKS     = CAL_LIMIT_MS * 1000 / TICK_US;

  // sample durations in microseconds, by code
  localparam int SAMP_US_0     = 320;
  localparam int SAMP_US_1     = 640;
  localparam int SAMP_US_2     = 1280;
  localparam int SAMP_US_3     = 2560;

  // cycle durations in milliseconds, by code
  localparam int CYC_MS_0      = 35;
  localparam int CYC_MS_1      = 70;
  localparam int CYC_MS_2      = 105;
  localparam int CYC_MS_3      = 140;

  // widths
  localparam int AW            = 8;                    // register address
  localparam int DW            = 8;                    // register data
  localparam int NCH           = 8;                    // touch inputs
  localparam int MW            = 16;                   // measurement value
  localparam int TRW           = 10;                   // offset trim value
  localparam int CHW           = 3;                    // channel index

  // register offsets
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h03;      // sticky events, read only
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h04;      // write one to clear, write only
  localparam logic [7:0] ADDR_SAMP_EN    = 8'h21;      // sampling enable per input
  localparam logic [7:0] ADDR_AVG_CFG    = 8'h24;      // averaging and sampling config
  localparam logic [7:0] ADDR_RECAL      = 8'h26;      // recalibration trigger
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h27;      // touch interrupt mask
  localparam logic [3:0] ADDR_TRIM_HI    = 4'h4;       // 0x40..0x4f trim readout window

  // reset values
  localparam logic [7:0] RST_SAMP_EN     = 8'hff;
  localparam logic [7:0] RST_AVG_CFG     = 8'h39;
  localparam logic [7:0] RST_RECAL       = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK    = 8'hff;

  // field positions inside the averaging config
  localparam int AVG_LSB       = 4;
  localparam int SAMP_LSB      = 2;
  localparam int CYC_LSB       = 0;
  localparam int TRIM_LO_W     = 2;                    // trim bits below the high byte

  // scan and calibration states
  typedef enum logic [1:0] {
    S_START = 2'h0,
    S_SEEK  = 2'h1,
    S_SAMP  = 2'h2,
    S_IDLE  = 2'h3
  } tsc_scan_t;

  typedef enum logic {
    C_IDLE = 1'h0,
    C_RUN  = 1'h1
  } tsc_cal_t;

  // ticks per sample
  function automatic logic [8:0] samp_ticks(input logic [1:0] code);
    case (code)
      2'h0:    samp_ticks = 9'(SAMP_US_0 / TICK_US);
      2'h1:    samp_ticks = 9'(SAMP_US_1 / TICK_US);
      2'h2:    samp_ticks = 9'(SAMP_US_2 / TICK_US);
      default: samp_ticks = 9'(SAMP_US_3 / TICK_US);
    endcase
  endfunction

  // ticks per scan cycle
  function automatic logic [18:0] cyc_ticks(input logic [1:0] code);
    case (code)
      2'h0:    cyc_ticks = 19'(CYC_MS_0 * 1000 / TICK_US);
      2'h1:    cyc_ticks = 19'(CYC_MS_1 * 1000 / TICK_US);
      2'h2:    cyc_ticks = 19'(CYC_MS_2 * 1000 / TICK_US);
      default: cyc_ticks = 19'(CYC_MS_3 * 1000 / TICK_US);
    endcase
  endfunction

  // index of the last sample of a channel, power of two minus one
  function automatic logic [6:0] avg_last(input logic [2:0] code);
    avg_last = 7'((8'h01 << code) - 8'h01);
  endfunction

endpackage

`default_nettype wire

/* src/tsc_tick.sv */
// fixed timebase: one-clock tick every tick_cycles clocks
`default_nettype none

module tsc_tick #(
  parameter int unsigned TICK_CYCLES = tsc_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // tick out
  output var  logic tick
);
  import tsc_pkg::*;

  localparam logic [15:0] LAST = 16'(TICK_CYCLES - 1);   // terminal count

  typedef struct packed {
    logic [15:0] cnt;                                    // clocks into this tick
    logic        tick;                                   // registered pulse
  } tsc_tick_st_t;

  tsc_tick_st_t q;
  tsc_tick_st_t next_q;

  // one timebase for every duration so each is an exact tick count
  always_comb begin
    next_q = q;
    next_q.tick = 1'b0;
    if (q.cnt >= LAST) begin // RULE_17
      next_q.cnt  = 16'h0000;
      next_q.tick = 1'b1;
    end else begin
      next_q.cnt = q.cnt + 16'h0001;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tick = q.tick;

endmodule

`default_nettype wire

/* src/tsc_sync.sv */
// two-flop synchroniser for pad inputs
`default_nettype none

module tsc_sync #(
  parameter int W = tsc_pkg::NCH
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // async in, synced out
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  import tsc_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;                                  // first stage, read only by second
    logic [W-1:0] sync;                                  // second stage
  } tsc_sync_st_t;

  tsc_sync_st_t s;
  tsc_sync_st_t next_s;

  // shift through both stages
  always_comb begin
    next_s      = s;
    next_s.meta = d;
    next_s.sync = s.meta;
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.sync;

endmodule

`default_nettype wire

/* src/tsc_top.sv */
// touch scan scheduler with recalibration triggers and masked touch interrupt
//
// Summary of operation
// RULE_01: samples per channel are two to avg code
// RULE_02: channel samples back to back, then averaged
// RULE_03: sample length chosen by two-bit code
// RULE_04: cycle length chosen by two-bit code
// RULE_05: sample enabled inputs first, then idle low power
// RULE_06: averaging overruns lengthen the cycle
// RULE_07: settings govern scanning in full active state
// RULE_08: averaging config resets to 39h
// RULE_09: trigger bit recalibrates input, cleared on success
// RULE_10: recalibrating input blocks presses, base invalid
// RULE_11: press during recalibration invalidates it
// RULE_12: finished recalibration updates ten-bit trim
// RULE_13: bits 0 to 7 map inputs 1 to 8
// RULE_14: touch or release interrupts only when unmasked
// RULE_15: masked touches still set status bit
// RULE_16: only enabled inputs measured, fixed cycle length
// RULE_17: all durations from one timebase tick
//
// Decided for this implementation: strobed register access.
`default_nettype none

module tsc_top #(
  parameter int unsigned TICK_CYCLES = tsc_pkg::TICK_CYCLES,
  parameter int unsigned CAL_TICKS   = tsc_pkg::CAL_TICKS
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // register port
  input  wire logic [tsc_pkg::AW-1:0]   reg_addr,
  input  wire logic [tsc_pkg::DW-1:0]   reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output var  logic [tsc_pkg::DW-1:0]   reg_rdata,
  // power state
  input  wire logic                     full_active,
  output var  logic                     low_power,
  // measurement front end
  input  wire logic [tsc_pkg::MW-1:0]   meas_value,
  output var  logic                     meas_active,
  output var  logic [tsc_pkg::CHW-1:0]  meas_channel,
  output var  logic                     result_valid,
  output var  logic [tsc_pkg::CHW-1:0]  result_channel,
  output var  logic [tsc_pkg::MW-1:0]   result_value,
  // touch detection
  input  wire logic [tsc_pkg::NCH-1:0]  pad_press,
  input  wire logic [tsc_pkg::NCH-1:0]  touch_event,
  input  wire logic [tsc_pkg::NCH-1:0]  release_event,
  input  wire logic                     release_irq_en,
  // recalibration front end
  input  wire logic                     cal_done,
  input  wire logic [tsc_pkg::TRW-1:0]  cal_trim,
  output var  logic                     cal_active,
  output var  logic [tsc_pkg::CHW-1:0]  cal_channel,
  output var  logic                     cal_abort,
  output var  logic [tsc_pkg::NCH-1:0]  base_invalid,
  // interrupt
  output var  logic                     irq
);
  import tsc_pkg::*;

  localparam logic [15:0] CAL_LAST = 16'(CAL_TICKS - 1); // last tick of the window

  typedef struct packed {
    logic [7:0]             samp_en;    // sampling enable per input
    logic [7:0]             cfg;        // averaging, sample and cycle codes
    logic [7:0]             recal;      // recalibration triggers
    logic [7:0]             mask;       // interrupt mask
    logic [7:0]             status;     // sticky touch events
    logic [NCH-1:0][TRW-1:0] trim;      // offset trim per input
    logic [7:0]             rdata;      // read data
    logic                   irq;        // interrupt level
    tsc_scan_t              scan_st;    // scan sequencer
    logic [2:0]             avg_l;      // cycle-latched averaging code
    logic [1:0]             samp_l;     // cycle-latched sample code
    logic [1:0]             cyc_l;      // cycle-latched cycle code
    logic [2:0]             ch;         // current channel
    logic [6:0]             smp;        // sample index in channel
    logic [8:0]             tcnt;       // ticks into sample
    logic [18:0]            cyc_cnt;    // ticks into cycle
    logic [18:0]            ch_ticks;   // ticks spent on channel
    logic [22:0]            acc;        // sample accumulator
    logic                   meas_active;
    logic                   low_power;
    logic                   res_valid;
    logic [2:0]             res_ch;
    logic [15:0]            res_val;
    tsc_cal_t               cal_st;     // recalibration sequencer
    logic [2:0]             cal_ch;
    logic [15:0]            cal_cnt;    // ticks into recalibration
    logic [7:0]             cal_block;  // presses suppressed, base invalid
    logic                   cal_abort;
  } tsc_st_t;

  tsc_st_t q;
  tsc_st_t next_q;

  logic [NCH-1:0] press_s;              // synchronised pad presses
  logic           tick;                 // timebase pulse
  logic [7:0]     ev;                   // qualified interrupt events
  logic [7:0]     clr_w;                // status clear from software
  logic [7:0]     recal_set;            // trigger ones from software
  logic [7:0]     recal_clr;            // trigger clear from hardware
  logic [2:0]     pick;                 // lowest pending trigger
  logic [22:0]    sum;                  // accumulator plus last sample

  // timebase
  tsc_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk  (clk),
    .rst  (rst),
    .tick (tick)
  );

  // pad press pins into clock domain
  tsc_sync #(
    .W (NCH)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (pad_press),
    .q   (press_s)
  );

  // next state of everything
  always_comb begin
    next_q    = q;
    ev        = 8'h00;
    clr_w     = 8'h00;
    recal_set = 8'h00;
    recal_clr = 8'h00;
    pick      = 3'h0;
    sum       = q.acc + 23'(meas_value);
    next_q.res_valid = 1'b0;
    next_q.cal_abort = 1'b0;
    next_q.rdata     = 8'h00;

    // register writes; unmapped addresses ignored
    if (reg_wr) begin
      case (reg_addr)
        ADDR_SAMP_EN:   next_q.samp_en = reg_wdata;
        ADDR_AVG_CFG:   next_q.cfg = reg_wdata;
        ADDR_RECAL:     recal_set = reg_wdata;
        ADDR_IRQ_MASK:  next_q.mask = reg_wdata;
        ADDR_IRQ_CLEAR: clr_w = reg_wdata;
        default: ;
      endcase
    end

    // register reads, zero for unmapped
    if (reg_rd) begin
      case (reg_addr)
        ADDR_IRQ_STATUS: next_q.rdata = q.status;
        ADDR_SAMP_EN:    next_q.rdata = q.samp_en;
        ADDR_AVG_CFG:    next_q.rdata = q.cfg;
        ADDR_RECAL:      next_q.rdata = q.recal;
        ADDR_IRQ_MASK:   next_q.rdata = q.mask;
        default: begin
          // trim window: even address high byte, odd low bits
          if (reg_addr[7:4] == ADDR_TRIM_HI) begin
            if (reg_addr[0]) begin
              next_q.rdata = {6'h00, q.trim[reg_addr[3:1]][TRIM_LO_W-1:0]};
            end else begin
              next_q.rdata = q.trim[reg_addr[3:1]][TRW-1:TRIM_LO_W];
            end
          end
        end
      endcase
    end

    // scan cycle timer runs in every state but the start
    if (tick && q.scan_st != S_START) begin
      next_q.cyc_cnt = q.cyc_cnt + 19'h0_0001;
    end

    // scan sequencer
    unique case (q.scan_st)
      S_START: begin
        // wait for full active, then latch settings for the cycle
        if (full_active) begin // RULE_07
          next_q.avg_l     = q.cfg[AVG_LSB+:3];
          next_q.samp_l    = q.cfg[SAMP_LSB+:2];
          next_q.cyc_l     = q.cfg[CYC_LSB+:2];
          next_q.cyc_cnt   = 19'h0_0000;
          next_q.ch        = 3'h0;
          next_q.low_power = 1'b0;
          next_q.scan_st   = S_SEEK;
        end
      end
      S_SEEK: begin
        // skip disabled inputs without spending time on them
        if (q.samp_en[q.ch]) begin // RULE_16
          next_q.smp         = 7'h00;
          next_q.tcnt        = 9'h000;
          next_q.acc         = 23'h00_0000;
          next_q.ch_ticks    = 19'h0_0000;
          next_q.meas_active = 1'b1;
          next_q.scan_st     = S_SAMP;
        end else if (q.ch == 3'h7) begin
          next_q.low_power = 1'b1;
          next_q.scan_st   = S_IDLE;
        end else begin
          next_q.ch = q.ch + 3'h1;
        end
      end
      S_SAMP: begin
        // samples of one channel back to back
        if (tick) begin
          next_q.ch_ticks = q.ch_ticks + 19'h0_0001;
          if (q.tcnt + 9'h001 == samp_ticks(q.samp_l)) begin // RULE_03
            next_q.tcnt = 9'h000;
            next_q.acc  = sum;
            if (q.smp == avg_last(q.avg_l)) begin // RULE_01
              // average by shifting, then move on
              next_q.res_valid   = 1'b1; // RULE_02
              next_q.res_ch      = q.ch;
              next_q.res_val     = 16'(sum >> q.avg_l);
              next_q.meas_active = 1'b0;
              if (q.ch == 3'h7) begin
                next_q.low_power = 1'b1;
                next_q.scan_st   = S_IDLE;
              end else begin
                next_q.ch      = q.ch + 3'h1;
                next_q.scan_st = S_SEEK;
              end
            end else begin
              next_q.smp = q.smp + 7'h01;
            end
          end else begin
            next_q.tcnt = q.tcnt + 9'h001;
          end
        end
      end
      S_IDLE: begin
        // low power for the rest of the cycle; overrun cycles end at once
        if (q.cyc_cnt >= cyc_ticks(q.cyc_l)) begin // RULE_04 RULE_05 RULE_06
          next_q.scan_st = S_START;
        end
      end
    endcase

    // lowest pending trigger wins
    for (int i = NCH - 1; i >= 0; i--) begin
      if (q.recal[i]) begin // RULE_13
        pick = 3'(i);
      end
    end

    // recalibration sequencer
    unique case (q.cal_st)
      C_IDLE: begin
        if (q.recal != 8'h00) begin // RULE_09
          next_q.cal_ch          = pick;
          next_q.cal_cnt         = 16'h0000;
          next_q.cal_block       = 8'h00;
          next_q.cal_block[pick] = 1'b1; // RULE_10
          next_q.cal_st          = C_RUN;
        end
      end
      C_RUN: begin
        if (press_s[q.cal_ch]) begin
          // press on the pad spoils the run; start it again
          next_q.cal_abort = 1'b1; // RULE_11
          next_q.cal_cnt   = 16'h0000;
        end else if (cal_done) begin
          next_q.trim[q.cal_ch]  = cal_trim; // RULE_12
          recal_clr[q.cal_ch]    = 1'b1; // RULE_09
          next_q.cal_block       = 8'h00;
          next_q.cal_st          = C_IDLE;
        end else if (tick) begin
          if (q.cal_cnt >= CAL_LAST) begin // RULE_10
            // window over without success; trigger stays for a retry
            next_q.cal_abort = 1'b1;
            next_q.cal_block = 8'h00;
            next_q.cal_st    = C_IDLE;
          end else begin
            next_q.cal_cnt = q.cal_cnt + 16'h0001;
          end
        end
      end
    endcase

    // trigger: software set wins over hardware clear
    next_q.recal = (q.recal & ~recal_clr) | recal_set;

    // touch, or release if allowed, on an input not recalibrating
    ev = (touch_event | (release_event & {NCH{release_irq_en}})) & ~q.cal_block; // RULE_10
    // status records every event, the mask only gates the pin
    next_q.status = (q.status & ~clr_w) | ev; // RULE_15
    next_q.irq    = |(next_q.status & next_q.mask); // RULE_14
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q         <= '0;
      q.samp_en <= RST_SAMP_EN;
      q.cfg     <= RST_AVG_CFG; // RULE_08
      q.recal   <= RST_RECAL;
      q.mask    <= RST_IRQ_MASK;
      q.scan_st <= S_START;
      q.cal_st  <= C_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from state
  assign reg_rdata      = q.rdata;
  assign low_power      = q.low_power;
  assign meas_active    = q.meas_active;
  assign meas_channel   = q.ch;
  assign result_valid   = q.res_valid;
  assign result_channel = q.res_ch;
  assign result_value   = q.res_val;
  assign cal_active     = q.cal_st == C_RUN;
  assign cal_channel    = q.cal_ch;
  assign cal_abort      = q.cal_abort;
  assign base_invalid   = q.cal_block;
  assign irq            = q.irq;

  // channel time equals sample count times sample length
  samp_total_a: assert property (@(posedge clk) disable iff (rst) // RULE_01
    q.res_valid |-> q.ch_ticks == 19'(({12'h000, avg_last(q.avg_l)} + 19'h0_0001) * samp_ticks(q.samp_l)))
    else $error("channel sampling time wrong");

  // result is the accumulated sum shifted by the averaging code
  avg_result_a: assert property (@(posedge clk) disable iff (rst) // RULE_02
    q.scan_st == S_SAMP && tick && q.tcnt + 9'h001 == samp_ticks(q.samp_l) && q.smp == avg_last(q.avg_l)
    |=> q.res_valid && q.res_val == 16'($past(sum) >> $past(q.avg_l)))
    else $error("averaged result wrong");

  // new cycle only after the programmed period has run out
  cycle_len_a: assert property (@(posedge clk) disable iff (rst) // RULE_04
    q.scan_st == S_START && $past(q.scan_st) == S_IDLE |-> $past(q.cyc_cnt) >= cyc_ticks(q.cyc_l))
    else $error("scan cycle ended early");

  // low power only in S_IDLE or S_START, never while measuring
  idle_power_a: assert property (@(posedge clk) disable iff (rst) // RULE_05
    q.low_power |-> q.scan_st != S_SAMP && !q.meas_active)
    else $error("low power while sampling");

  // overrun cycle restarts with no idle time
  cycle_ext_a: assert property (@(posedge clk) disable iff (rst) // RULE_06
    q.scan_st == S_IDLE && q.cyc_cnt >= cyc_ticks(q.cyc_l) |=> q.scan_st == S_START)
    else $error("extended cycle did not restart");

  // no scan cycle starts outside full active
  active_gate_a: assert property (@(posedge clk) disable iff (rst) // RULE_07
    q.scan_st == S_START && !full_active |=> q.scan_st == S_START)
    else $error("scan started while not fully active");

  // config reset value
  cfg_reset_a: assert property (@(posedge clk) disable iff (rst) // RULE_08
    $past(rst) |-> q.cfg == RST_AVG_CFG)
    else $error("config reset value wrong");

  // successful run clears its trigger unless software sets it again
  recal_clear_a: assert property (@(posedge clk) disable iff (rst) // RULE_09
    q.cal_st == C_RUN && cal_done && !press_s[q.cal_ch] && !(reg_wr && reg_addr == ADDR_RECAL)
    |=> !q.recal[$past(q.cal_ch)] && q.trim[$past(q.cal_ch)] == $past(cal_trim))
    else $error("trigger or trim not updated on completion");

  // presses blocked on the recalibrating input within the window
  cal_block_a: assert property (@(posedge clk) disable iff (rst) // RULE_10
    q.cal_st == C_RUN |-> q.cal_block[q.cal_ch] && q.cal_cnt <= CAL_LAST)
    else $error("recalibrating input not blocked");

  // press during a run aborts it in the next cycle
  press_abort_a: assert property (@(posedge clk) disable iff (rst) // RULE_11
    q.cal_st == C_RUN && press_s[q.cal_ch] |=> q.cal_abort && q.cal_cnt == 16'h0000)
    else $error("press did not invalidate recalibration");

  // masked event records status but leaves the pin low
  masked_touch_a: assert property (@(posedge clk) disable iff (rst) // RULE_15
    (ev & ~q.mask) != 8'h00 && (ev & q.mask) == 8'h00 && (q.status & q.mask) == 8'h00
    && !(reg_wr && reg_addr == ADDR_IRQ_MASK)
    |=> (q.status & $past(ev)) == $past(ev) && !q.irq)
    else $error("masked touch handled wrong");

  // pin high exactly while an unmasked status bit is set
  irq_level_a: assert property (@(posedge clk) disable iff (rst) // RULE_14
    q.irq == |(q.status & q.mask))
    else $error("interrupt pin disagrees with status");

  // disabled input takes no measurement time
  skip_off_a: assert property (@(posedge clk) disable iff (rst) // RULE_16
    q.scan_st == S_SEEK && !q.samp_en[q.ch] |=> !q.meas_active)
    else $error("disabled input measured");

endmodule

`default_nettype wire

/* testbench/tsc_fe_model.sv */
// front-end stand-in: constant samples and slow recalibration answers
`default_nettype none
module tsc_fe_model (
  // clock
  input  wire logic        clk,
  // front end
  input  wire logic        cal_active,
  output var  logic [15:0] meas_value,
  output var  logic        cal_done,
  output var  logic [9:0]  cal_trim
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;                // clocks into a run
  initial cal_done = 1'b0;
  initial cal_trim = 10'h000;
  assign meas_value = 16'h1234;
  // answers success 20 clocks into a run, trim lines toggle otherwise
  always @(posedge clk) begin
    n <= (cal_active && !cal_done) ? n + 1 : 0;
    cal_done <= cal_active && n == 20;
    cal_trim <= (cal_active && n == 20) ? 10'h2a5 : ~cal_trim;
  end
endmodule
`default_nettype wire

/* testbench/tb_tsc_top.sv */
// self-checking bench of the touch scan scheduler
`default_nettype none
module tb_tsc_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tsc_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, fa = 0, rie = 0, rd_q = 0;
  logic [7:0] addr = 0, wd = 0, rdata, pp = 0, te = 0, re = 0, base;
  logic [15:0] mv, rv;
  logic [9:0] tr;
  logic [2:0] mch, rch, cch;
  logic lp, ma, rvld, cd, ca, cab, irq;
  logic [7:0] rq[$];        // expected read data
  logic [2:0] cq[$];        // expected result channels
  int err_count = 0, cmp_count = 0, seed = 95, b, k;
  always #50 clk = ~clk;
  tsc_top #(.TICK_CYCLES(1), .CAL_TICKS(50)) i_tsc_top (.clk(clk), .rst(rst), .reg_addr(addr),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .full_active(fa), .low_power(lp),
    .meas_value(mv), .meas_active(ma), .meas_channel(mch), .result_valid(rvld), .result_channel(rch),
    .result_value(rv), .pad_press(pp), .touch_event(te), .release_event(re), .release_irq_en(rie),
    .cal_done(cd), .cal_trim(tr), .cal_active(ca), .cal_channel(cch), .cal_abort(cab),
    .base_invalid(base), .irq(irq));
  tsc_fe_model i_tsc_fe_model (.clk(clk), .cal_active(ca), .meas_value(mv), .cal_done(cd), .cal_trim(tr));
  // compare one value, count and report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one-cycle bus strobes; the next bus call or cyc lowers them, so back to back calls assign once
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    addr <= a; wd <= d; wr <= 1; rd <= 0; @(posedge clk);
  endtask
  task automatic rdr(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e); addr <= a; rd <= 1; wr <= 0; @(posedge clk);
  endtask
  task automatic cyc(input int n);
    wr <= 0; rd <= 0; repeat (n) @(posedge clk);
  endtask
  // watcher: read data in the cycle after the strobe, results in order
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q) chk(rdata, rq.pop_front());
    if (ma && cq.size() > 0) chk(mch, cq[0]);
    if (rvld) begin
      chk(rch, cq.pop_front());
      chk(rv, 16'h1234);
    end
  end
  initial begin
    #2ms err_count++;
    give_verdict();
  end
  initial begin
    cyc(3); rst <= 0; b = $random(seed) & 7;
    rdr(ADDR_AVG_CFG, 8'h39);
    rdr(ADDR_RECAL, 8'h00); rdr(ADDR_IRQ_MASK, 8'hff);
    rdr(ADDR_SAMP_EN, 8'hff); rdr(8'h10, 8'h00); cyc(1);
    // scan inputs 1 and 3, two samples of 32 ticks each
    wrr(ADDR_SAMP_EN, 8'h05); wrr(ADDR_AVG_CFG, 8'h10); cq = '{3'd0, 3'd2};
    fa <= 1; cyc(1); k = 0;
    for (int i = 0; i < 400 && !lp; i++) begin @(posedge clk); k += ma; end
    fa <= 0;
    chk(16'(k inside {[124:132]}), 1);
    chk(lp, 1); chk(cq.size(), 0);
    // masked touch keeps status but no interrupt
    wrr(ADDR_IRQ_MASK, ~(8'h01 << b)); te <= 8'h01 << b; cyc(1); te <= 0; cyc(2);
    chk(irq, 0);
    rdr(ADDR_IRQ_STATUS, 8'h01 << b);
    wrr(ADDR_IRQ_MASK, 8'hff); cyc(2); chk(irq, 1);
    wrr(ADDR_IRQ_CLEAR, 8'hff); cyc(2); chk(irq, 0);
    re <= 8'h01 << b; cyc(1); re <= 0; cyc(2); chk(irq, 0);
    rie <= 1; re <= 8'h01 << b; cyc(1); re <= 0; cyc(2); chk(irq, 1);
    wrr(ADDR_IRQ_CLEAR, 8'hff);
    // recalibration: press aborts, touches ignored, then success
    wrr(ADDR_RECAL, 8'h01 << b); cyc(3); chk(base, 8'h01 << b); chk(cch, 3'(b));
    te <= 8'h01 << b; pp <= 8'h01 << b; k = 0;
    for (int i = 0; i < 8; i++) begin @(posedge clk); te <= 0; k |= cab; end
    pp <= 0; chk(k, 1); chk(irq, 0);
    for (int i = 0; i < 200 && ca; i++) @(posedge clk);
    cyc(2); rdr(ADDR_RECAL, 8'h00);
    rdr(8'h40 + 8'(2 * b), 8'ha9); rdr(8'h41 + 8'(2 * b), 8'h01);
    cyc(3); give_verdict();
  end
endmodule
`default_nettype wire
